//--- shared/dbgm_consts.svh
// constants of the two-wire debug link master
`ifndef DBGM_CONSTS_SVH
`define DBGM_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets on the avalon side
// ------------------------------------------------------------
`define DBGM_OFS_CMD      4'h0
`define DBGM_OFS_STAT     4'h4
`define DBGM_OFS_RDATA    4'h8

// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define DBGM_CMD_BYTE_LO  0
`define DBGM_CMD_BYTE_HI  7
`define DBGM_CMD_HDR      8
`define DBGM_CMD_RD       9
`define DBGM_CMD_SEP      10

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define DBGM_STAT_BUSY    0
`define DBGM_STAT_SESS    1
`define DBGM_STAT_REFUSED 2
`define DBGM_STAT_SEP     3

// ------------------------------------------------------------
// timing: one half period of the link clock
// ------------------------------------------------------------
`define DBGM_SYS_MHZ      200
`define DBGM_HALF_NS      65
`define DBGM_HALF_CYC     ((`DBGM_HALF_NS * `DBGM_SYS_MHZ + 999) / 1000)
`define DBGM_LAST_BIT     4'h8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DBGM_RST_PIN      1'b1
`define DBGM_RST_DATA     32'h0000_0000

`endif

//--- shared/dbgm_pkg.sv
// types of the two-wire debug link master
`default_nettype none
package dbgm_pkg;

   // one order from software to the link engine
   typedef struct packed {
      logic       sep;       // separator value sent after the byte
      logic       rd;        // without hdr, device drives the eight data bits
      logic       hdr;       // precede byte by a start marker
      logic [7:0] byte_val;  // address+direction or write data
   } dbgm_cmd_t;

   // link pins as driven by the master
   typedef struct packed {
      logic clk;   // debug clock level
      logic dat;   // debug data level when driven
      logic oe;    // high while the master drives data
   } dbgm_pins_t;

   // link engine states
   typedef enum logic [1:0] {
      DBGM_IDLE,
      DBGM_START,
      DBGM_LOW,
      DBGM_HIGH
   } dbgm_state_t;

endpackage

`default_nettype wire

//--- hw/dbgm_master.sv
// master end of the two-wire debug link with an avalon-mm register port
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "dbgm_consts.svh"

module dbgm_master (
   input  wire logic        clk_sys,          // 200 mhz system clock
   input  wire logic        sys_rst,          // async reset, active high
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data
   output var  logic [31:0] avs_readdata,     // read data, registered
   output logic             avs_waitrequest,  // stall
   // debug link pins
   output logic             debug_clock_pin,  // link clock we make
   input  wire logic        debug_data_in,    // data pin level
   output logic             debug_data_out,   // data pin drive value
   output logic             debug_data_oe     // data pin drive enable
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   // half period is fixed, so the link runs at one rate only
   localparam logic [4:0] HALF = 5'(`DBGM_HALF_CYC);  // half period

   dbgm_pkg::dbgm_state_t state_ff, nxt_state;       // engine state
   logic [4:0]            tmr_ff, nxt_tmr;           // phase timer
   logic [3:0]            bit_ff, nxt_bit;           // bit of frame
   logic [8:0]            shf_ff, nxt_shf;           // bits to send
   logic [7:0]            rx_ff, nxt_rx;             // bits received
   logic                  rd_ff, nxt_rd;             // frame is a read
   dbgm_pkg::dbgm_pins_t  pin_ff, nxt_pin;           // driven pins
   logic                  sess_ff, nxt_sess;         // header was sent
   logic                  sep_ff, nxt_sep;           // last separator
   logic                  refused_ff, nxt_refused;   // last cmd refused
   logic [7:0]            rdata_ff, nxt_rdata;       // last read byte
   logic                  din_s1_ff, din_s2_ff;      // data synchroniser
   logic                  rd_pend_ff, nxt_rd_pend;   // read wait cycle
   logic [31:0]           rdd_ff, nxt_rdd;           // read data
   // combinational decode of the bus side
   dbgm_pkg::dbgm_cmd_t   cmd;                       // decoded order
   logic                  cmd_sel;                   // write hits cmd
   logic                  busy;                      // engine running
   logic                  accept;                    // order taken

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // true when the byte address is the given register
   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // bus side decode
   // ------------------------------------------------------------
   // cast the write word onto the command layout
   always_comb begin
      cmd.byte_val = avs_writedata[`DBGM_CMD_BYTE_HI:`DBGM_CMD_BYTE_LO];
      cmd.hdr      = avs_writedata[`DBGM_CMD_HDR];
      cmd.rd       = avs_writedata[`DBGM_CMD_RD];
      cmd.sep      = avs_writedata[`DBGM_CMD_SEP];
   end

   // the engine owns the link everywhere outside idle
   assign busy    = (state_ff != dbgm_pkg::DBGM_IDLE);
   assign cmd_sel = avs_write && hit(avs_address, `DBGM_OFS_CMD);
   // a command write stalls while a frame is on the link
   assign accept  = cmd_sel && !busy;

   // stall reads one cycle, and command writes while busy
   assign avs_waitrequest = (avs_read && !rd_pend_ff) || (cmd_sel && busy);
   assign avs_readdata    = rdd_ff;

   // ------------------------------------------------------------
   // register read path
   // ------------------------------------------------------------
   // first read cycle captures the word, second one answers
   // status flags are those of the capture cycle
   always_comb begin
      nxt_rd_pend = avs_read && !rd_pend_ff;
      nxt_rdd     = rdd_ff;
      if (avs_read && !rd_pend_ff) begin
         nxt_rdd = `DBGM_RST_DATA;   // unmapped reads as zero
         if (hit(avs_address, `DBGM_OFS_STAT)) begin
            nxt_rdd[`DBGM_STAT_BUSY]    = busy;
            nxt_rdd[`DBGM_STAT_SESS]    = sess_ff;
            nxt_rdd[`DBGM_STAT_REFUSED] = refused_ff;
            nxt_rdd[`DBGM_STAT_SEP]     = sep_ff;
         end else if (hit(avs_address, `DBGM_OFS_RDATA)) begin
            nxt_rdd[7:0] = rdata_ff;
         end
      end
   end

   // register the read path
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // nothing pending, read word cleared
         rd_pend_ff <= 1'b0;
         rdd_ff     <= `DBGM_RST_DATA;
      end else begin
         // take the next values of the read path
         rd_pend_ff <= nxt_rd_pend;
         rdd_ff     <= nxt_rdd;
      end
   end

   // ------------------------------------------------------------
   // data pin synchroniser
   // ------------------------------------------------------------
   // two flops before the engine looks at the pin
   // only the second stage is read by the engine
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // both stages rest at the pulled-up level
         din_s1_ff <= `DBGM_RST_PIN;
         din_s2_ff <= `DBGM_RST_PIN;
      end else begin
         din_s1_ff <= debug_data_in;
         din_s2_ff <= din_s1_ff;
      end
   end

   // ------------------------------------------------------------
   // link engine
   // ------------------------------------------------------------
   // frame: optional start, then nine bits of two half periods each
   always_comb begin
      nxt_state   = state_ff;
      nxt_tmr     = tmr_ff;
      nxt_bit     = bit_ff;
      nxt_shf     = shf_ff;
      nxt_rx      = rx_ff;
      nxt_rd      = rd_ff;
      nxt_pin     = pin_ff;
      nxt_sess    = sess_ff;
      nxt_sep     = sep_ff;
      nxt_refused = refused_ff;
      nxt_rdata   = rdata_ff;
      unique case (state_ff)
         // clock held high between frames
         dbgm_pkg::DBGM_IDLE: begin
            if (accept) begin
               // load the byte and its separator into the shifter
               nxt_shf = {cmd.byte_val, cmd.sep};
               nxt_bit = 4'h0;
               nxt_tmr = HALF;
               if (cmd.hdr && sess_ff && !sep_ff) begin
                  // a new start after a zero separator is refused
                  nxt_refused = 1'b1;
               end else if (!cmd.hdr && !sess_ff) begin
                  // a data byte before any header is refused
                  nxt_refused = 1'b1;
               end else if (cmd.hdr) begin
                  // falling data with clock high marks the start
                  nxt_refused = 1'b0;
                  nxt_rd      = 1'b0;
                  nxt_pin.dat = 1'b0;
                  nxt_pin.oe  = 1'b1;
                  nxt_state   = dbgm_pkg::DBGM_START;
               end else begin
                  // no start: the device repeats the last operation
                  nxt_refused = 1'b0;
                  nxt_rd      = cmd.rd;
                  nxt_pin.clk = 1'b0;
                  // let go of data as the clock falls, so the ends never fight
                  nxt_pin.oe  = !cmd.rd;
                  nxt_state   = dbgm_pkg::DBGM_LOW;
               end
            end
         end
         // hold the start marker for one half period
         dbgm_pkg::DBGM_START: begin
            nxt_tmr = tmr_ff - 5'h01;
            // clock falls once the marker has stood long enough
            if (tmr_ff == 5'h01) begin
               nxt_tmr     = HALF;
               nxt_pin.clk = 1'b0;
               nxt_state   = dbgm_pkg::DBGM_LOW;
            end
         end
         // low phase: bit data changes only here, one cycle after fall
         dbgm_pkg::DBGM_LOW: begin
            nxt_tmr = tmr_ff - 5'h01;
            if (tmr_ff == HALF) begin
               nxt_pin.dat = shf_ff[8];
               // release data while the device shifts a read byte
               nxt_pin.oe  = !(rd_ff && bit_ff != `DBGM_LAST_BIT);
            end
            // clock rises once the low phase has run out
            if (tmr_ff == 5'h01) begin
               nxt_tmr     = HALF;
               nxt_pin.clk = 1'b1;
               nxt_state   = dbgm_pkg::DBGM_HIGH;
            end
         end
         // high phase: sample at its end, then next bit or halt
         dbgm_pkg::DBGM_HIGH: begin
            nxt_tmr = tmr_ff - 5'h01;
            if (tmr_ff == 5'h01) begin
               nxt_shf = {shf_ff[7:0], 1'b0};
               // the read bit is taken as late in the high phase as can be
               if (bit_ff != `DBGM_LAST_BIT) begin
                  nxt_rx = {rx_ff[6:0], din_s2_ff};
               end
               if (bit_ff == `DBGM_LAST_BIT) begin
                  // stop in the ninth cycle with clock high
                  nxt_sess  = 1'b1;
                  nxt_sep   = pin_ff.dat;
                  if (rd_ff) begin
                     nxt_rdata = rx_ff;
                  end
                  nxt_state = dbgm_pkg::DBGM_IDLE;
               end else begin
                  // another bit of the frame follows
                  nxt_bit     = bit_ff + 4'h1;
                  nxt_tmr     = HALF;
                  nxt_pin.clk = 1'b0;
                  // let go of data as the clock falls before a read bit
                  if (rd_ff && nxt_bit != `DBGM_LAST_BIT) begin
                     nxt_pin.oe = 1'b0;
                  end
                  nxt_state   = dbgm_pkg::DBGM_LOW;
               end
            end
         end
      endcase
   end

   // register the link engine
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // clock and data idle high, no session open
         state_ff   <= dbgm_pkg::DBGM_IDLE;
         tmr_ff     <= 5'h00;
         bit_ff     <= 4'h0;
         shf_ff     <= 9'h000;
         rx_ff      <= 8'h00;
         rd_ff      <= 1'b0;
         pin_ff     <= '{clk: 1'b1, dat: 1'b1, oe: 1'b1};
         sess_ff    <= 1'b0;
         sep_ff     <= 1'b1;
         refused_ff <= 1'b0;
         rdata_ff   <= 8'h00;
      end else begin
         // every register takes its next value
         state_ff   <= nxt_state;
         tmr_ff     <= nxt_tmr;
         bit_ff     <= nxt_bit;
         shf_ff     <= nxt_shf;
         rx_ff      <= nxt_rx;
         rd_ff      <= nxt_rd;
         pin_ff     <= nxt_pin;
         sess_ff    <= nxt_sess;
         sep_ff     <= nxt_sep;
         refused_ff <= nxt_refused;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------
   // pin outputs
   // ------------------------------------------------------------
   // pins come straight from flops, so no glitch reaches the link
   assign debug_clock_pin = pin_ff.clk;
   assign debug_data_out  = pin_ff.dat;
   assign debug_data_oe   = pin_ff.oe;

endmodule

`default_nettype wire

//--- test/dbgm_master_chk.sv
// assertion checker for the debug link master
`timescale 1ns/1ps
`default_nettype none

module dbgm_master_chk (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        avs_read,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic        debug_clock_pin,
   input wire logic        debug_data_out,
   input wire logic        debug_data_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // --------
   // frame helpers
   // --------
   logic       clk_q_ff, nxt_clk_q;  // clock one cycle back
   logic       dat_q_ff, nxt_dat_q;  // data one cycle back
   logic [5:0] hi_ff, nxt_hi;        // cycles with clock high
   logic [3:0] mod_ff, nxt_mod;      // rises modulo nine
   // start resets the count, each rise advances it
   always_comb begin
      nxt_clk_q = debug_clock_pin;
      nxt_dat_q = debug_data_out;
      nxt_hi = (hi_ff == 6'h3F) ? hi_ff : hi_ff + 6'h01;
      if (!debug_clock_pin) nxt_hi = 6'h00;
      nxt_mod = mod_ff;
      if (debug_clock_pin && !clk_q_ff)
         nxt_mod = (mod_ff == 4'h8) ? 4'h0 : mod_ff + 4'h1;
      if (debug_clock_pin && dat_q_ff && !debug_data_out && debug_data_oe)
         nxt_mod = 4'h0;
   end
   // registers of the helpers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {clk_q_ff, dat_q_ff, hi_ff, mod_ff} <= {2'b11, 6'h00, 4'h0};
      end else begin
         {clk_q_ff, dat_q_ff} <= {nxt_clk_q, nxt_dat_q};
         {hi_ff, mod_ff} <= {nxt_hi, nxt_mod};
      end
   end
   // --------
   // assertions
   // --------
   clk_low_a: assert property ($fell(debug_clock_pin) |->
      (!debug_clock_pin)[*8] ##[1:8] debug_clock_pin)
      else $error("link clock low phase wrong");
   clk_high_a: assert property ($rose(debug_clock_pin) |->
      debug_clock_pin[*8]) else $error("link clock high too short");
   data_edge_a: assert property (debug_data_oe && $past(debug_data_oe)
      && debug_clock_pin && $past(debug_clock_pin)
      && $changed(debug_data_out) |-> !debug_data_out)
      else $error("data rose while clock high");
   oe_turn_a: assert property ($rose(debug_data_oe) |->
      !debug_clock_pin && !$past(debug_clock_pin))
      else $error("data taken back outside low phase");
   oe_release_a: assert property ($fell(debug_data_oe) |->
      $fell(debug_clock_pin)) else $error("data not let go at clock fall");
   byte_len_a: assert property (hi_ff == 6'h1E |-> mod_ff == 4'h0)
      else $error("frame not a whole number of nine clocks");
   start_hold_a: assert property (debug_clock_pin && debug_data_oe
      && $fell(debug_data_out) |-> debug_clock_pin[*8] ##[1:10]
      !debug_clock_pin) else $error("start not followed by clocks");
   rd_wait_a: assert property ($rose(avs_read) |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait not one cycle");
   rdata_hold_a: assert property ($changed(avs_readdata) |->
      $past(avs_read)) else $error("read data moved without read");
   start_c: cover property (mod_ff == 4'h0 && hi_ff == 6'h1E);
   turn_c: cover property ($fell(debug_data_oe));
   read_c: cover property (avs_read && !avs_waitrequest);
endmodule

bind dbgm_master dbgm_master_chk dbgm_master_chk_i (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
   .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .debug_clock_pin(debug_clock_pin), .debug_data_out(debug_data_out),
   .debug_data_oe(debug_data_oe));
`default_nettype wire

//--- test/dbgm_dev_model.sv
// behavioural model of the debug port device
`timescale 1ns/1ps
`default_nettype none

module dbgm_dev_model (
   input  wire logic link_clk,  // clock made by the master
   input  wire logic link_dat,  // resolved data line
   output logic      drv_val,   // value we drive
   output logic      drv_oe     // high while we drive
);
   logic [7:0] wr_reg [0:127];  // write-only space, reads return the address with a one bit appended instead
   logic [7:0] sh;              // shifter
   logic [6:0] addr;            // register address
   logic [3:0] cnt;             // bit within the frame
   logic       act, hdr, rd;    // started, header frame, read op
   // never drives the clock, waits for a start
   initial {act, drv_oe, drv_val} = 3'b001;
   // grant enable is never written, so no bus grant is given
   // pins serve the link alone, boundary scan is off
   // pin edges are used as they come, for the synchroniser
   // only a falling data edge with clock high starts
   always @(negedge link_dat) if (link_clk) begin
      {act, hdr, cnt, drv_oe} = {2'b11, 4'h0, 1'b0};
   end
   // capture on rise, msb first, ninth clock does the work
   always @(posedge link_clk) if (act) begin
      if (cnt == 4'h8) begin
         if (hdr) {addr, rd} = sh;
         else if (!rd) begin
            wr_reg[addr] = sh;
            if (addr < 7'h30) addr++;
         end else if (addr < 7'h20) addr++;
         {hdr, cnt} = 5'h00;
      end else begin
         if (hdr || !rd) sh = {sh[6:0], link_dat};
         cnt++;
      end
   end
   // drive read bits on the fall, load at frame start
   always @(negedge link_clk) if (act && rd && !hdr) begin
      // a register read moves no program counter here
      if (cnt == 4'h0) sh = {addr, 1'b1};
      drv_oe = (cnt != 4'h8);
      drv_val = sh[3'h7 - cnt[2:0]];
   end
endmodule
`default_nettype wire

//--- test/dbgm_master_bench.sv
// self-checking bench of the debug link master
`timescale 1ns/1ps
`default_nettype none
`include "dbgm_consts.svh"

module dbgm_master_bench;
   logic        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        debug_clock_pin, debug_data_out, debug_data_oe;
   logic        dev_val, dev_oe, debug_data_in;  // device side, line
   int          bad_count, total_checks;
   // pulled-up line, master wins a clash
   assign debug_data_in = debug_data_oe ? debug_data_out
                                        : (dev_oe ? dev_val : 1'b1);
   dbgm_master dbgm_master_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .debug_clock_pin(debug_clock_pin), .debug_data_in(debug_data_in),
      .debug_data_out(debug_data_out), .debug_data_oe(debug_data_oe));
   dbgm_dev_model dbgm_dev_model_i (.link_clk(debug_clock_pin),
      .link_dat(debug_data_in), .drv_val(dev_val), .drv_oe(dev_oe));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // --------
   // shared tasks
   // --------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus transfer held until waitrequest is low
   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      {avs_address, avs_writedata} <= {a, d};
      {avs_write, avs_read} <= {w, !w};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 4000);
      // read data is taken at the very edge that ends the wait
      q = avs_readdata;
      if (n >= 4000) bad_count++;
      {avs_write, avs_read} <= 2'b00;
   endtask
   task automatic rd8(input logic [3:0] a, output logic [7:0] b);
      logic [31:0] q;
      av(1'b0, a, 32'h0, q);
      b = q[7:0];
   endtask
   // issue one order, then poll until the engine is idle
   task automatic cmd(input logic s, input logic r, input logic h,
                      input logic [7:0] b);
      dbgm_pkg::dbgm_cmd_t c;
      logic [31:0] q;
      c = '{sep: s, rd: r, hdr: h, byte_val: b};
      av(1'b1, `DBGM_OFS_CMD, {21'h0, c}, q);
      q = 32'h1;
      for (int i = 0; i < 300 && q[`DBGM_STAT_BUSY] !== 1'b0; i++)
         av(1'b0, `DBGM_OFS_STAT, 32'h0, q);
      if (q[`DBGM_STAT_BUSY] !== 1'b0) bad_count++;
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_idle;
      logic [7:0] b;
      chk("clock idle", 8'h01, {7'h0, debug_clock_pin});
      rd8(`DBGM_OFS_RDATA, b);
      chk("rdata reset", 8'h00, b);
      rd8(4'hC, b);
      chk("unmapped", 8'h00, b);
      cmd(1'b1, 1'b0, 1'b0, 8'h55);
      rd8(`DBGM_OFS_STAT, b);
      chk("no header", 8'h04, b & 8'h07);
      $display("test idle done");
   endtask
   task automatic t_wr;
      logic [7:0] b;
      logic [31:0] q;
      // header written raw, so the data order below stalls on the bus
      av(1'b1, `DBGM_OFS_CMD, 32'h0000_0520, q);
      cmd(1'b1, 1'b0, 1'b0, 8'hA5);
      chk("single write", 8'hA5, dbgm_dev_model_i.wr_reg[7'h10]);
      cmd(1'b0, 1'b0, 1'b1, {7'h2E, 1'b0});
      for (int i = 0; i < 4; i++)
         cmd(i == 3, 1'b0, 1'b0, 8'(8'h11 * (i + 1)));
      chk("block first", 8'h11, dbgm_dev_model_i.wr_reg[7'h2E]);
      chk("block next", 8'h22, dbgm_dev_model_i.wr_reg[7'h2F]);
      chk("block top", 8'h44, dbgm_dev_model_i.wr_reg[7'h30]);
      rd8(`DBGM_OFS_STAT, b);
      chk("separator one", 8'h08, b & 8'h0C);
      $display("test write done");
   endtask
   task automatic t_rd;
      logic [7:0] b;
      cmd(1'b0, 1'b1, 1'b1, {7'h1F, 1'b1});
      for (int i = 0; i < 3; i++) begin
         cmd(1'b0, 1'b1, 1'b0, 8'hFF);
         rd8(`DBGM_OFS_RDATA, b);
         chk("block read", (i == 0) ? 8'h3F : 8'h41, b);
      end
      cmd(1'b1, 1'b0, 1'b1, 8'h00);
      rd8(`DBGM_OFS_STAT, b);
      chk("start after zero", 8'h04, b & 8'h0C);
      cmd(1'b1, 1'b1, 1'b0, 8'hFF);
      cmd(1'b1, 1'b1, 1'b1, {7'h05, 1'b1});
      cmd(1'b1, 1'b1, 1'b0, 8'hFF);
      rd8(`DBGM_OFS_RDATA, b);
      chk("fresh read", 8'h0B, b);
      $display("test read done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {sys_rst, avs_read, avs_write} = 3'b100;
      {avs_address, avs_writedata} = 36'h0;
      {bad_count, total_checks} = 64'h0;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_idle;
      t_wr;
      t_rd;
      final_report;
   end
   // watchdog well beyond the expected run
   initial begin
      #400000;
      bad_count++;
      final_report;
   end
endmodule
`default_nettype wire
